// file: design/ssm_pkg.sv
// Package for the synchronous serial master/slave port: map, fields, carriers
package ssm_pkg;

	// Register byte addresses, one 32-bit word each
	localparam logic [7:0] ADDR_BAUD_CONTROL_ONE          = 8'h00;
	localparam logic [7:0] ADDR_RECEIVE_STATUS_CONTROL_ONE = 8'h04;
	localparam logic [7:0] ADDR_TRANSMIT_STATUS_CONTROL_ONE = 8'h08;
	localparam logic [7:0] ADDR_BAUD_DIVISOR_LOW_ONE      = 8'h0c;
	localparam logic [7:0] ADDR_BAUD_DIVISOR_HIGH_ONE     = 8'h10;
	localparam logic [7:0] ADDR_TRANSMIT_HOLDING_ONE      = 8'h14;
	localparam logic [7:0] ADDR_RECEIVE_HOLDING_ONE       = 8'h18;

	// Baud control fields
	localparam int BIT_CLOCK_POLARITY = 4;
	localparam int BIT_DATA_POLARITY  = 5;
	// Receive status/control fields
	localparam int BIT_PORT_ENABLE    = 7;
	localparam int BIT_NINE_RX        = 6;
	localparam int BIT_SINGLE_RX      = 5;
	localparam int BIT_CONT_RX        = 4;
	localparam int BIT_RX_FLAG        = 3;
	localparam int BIT_OVERRUN        = 1;
	localparam int BIT_NINTH_RX       = 0;
	// Transmit status/control fields
	localparam int BIT_MASTER_CLOCK   = 7;
	localparam int BIT_NINE_TX        = 6;
	localparam int BIT_TX_ENABLE      = 5;
	localparam int BIT_SYNC_MODE      = 4;
	localparam int BIT_TX_IDLE        = 1;
	localparam int BIT_NINTH_TX       = 0;

	// Character lengths and reset values
	localparam logic [3:0] BITS_SHORT    = 4'h8;
	localparam logic [3:0] BITS_LONG     = 4'h9;
	localparam logic [7:0] RESET_DIVISOR = 8'h00;

	// Pin group: clock line and data line, two signals each
	typedef struct packed {
		logic clock_line;
		logic clock_line_oe;
		logic data_line;
		logic data_line_oe;
	} ssm_pins_type;

	// Whole state of the port
	typedef struct packed {
		logic [1:0]      sync1;
		logic [1:0]      sync2;
		logic            ck_prev;
		logic            clk_pol;
		logic            dat_pol;
		logic            port_en;
		logic            nine_rx;
		logic            single_rx;
		logic            cont_rx;
		logic            master;
		logic            nine_tx;
		logic            tx_en;
		logic            sync_mode;
		logic            ninth_tx;
		logic [7:0]      div_lo;
		logic [7:0]      div_hi;
		logic [15:0]     baud_cnt;
		logic            phase;
		ssm_pins_type    pins;
		logic [8:0]      txh;
		logic            txh_full;
		logic [8:0]      transmit_shift_register;
		logic            tx_busy;
		logic [3:0]      tx_cnt;
		logic [8:0]      receive_shift_register;
		logic [3:0]      rx_cnt;
		logic [1:0][8:0] fifo;
		logic            head;
		logic [1:0]      count;
		logic            ovr;
		logic            ovr_single;
		logic            rx_flag;
		logic            pready;
		logic            pslverr;
		logic [31:0]     prdata;
	} ssm_state_type;

endpackage

// file: design/ssm_port.sv
// Synchronous serial port: APB registers, master clock, shift logic, receive FIFO
`timescale 1ns/100ps
`default_nettype none
module ssm_port
	import ssm_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output var  logic [31:0] prdata_out,
	output var  logic        pready_out,
	output var  logic        pslverr_out,
	input  wire logic        clock_line_in,
	output var  logic        clock_line_out,
	output var  logic        clock_line_oe_out,
	input  wire logic        data_line_in,
	output var  logic        data_line_out,
	output var  logic        data_line_oe_out,
	output var  logic        receive_interrupt_flag_out
);

	ssm_state_type q;
	ssm_state_type d;

	logic        access;
	logic        wr_done;
	logic        rd_done;
	logic        mapped;
	logic        rx_mode;
	logic        tx_mode;
	logic        mst_run;
	logic        lead;
	logic        trail;
	logic        rx_done;
	logic        push;
	logic        pop;
	logic [3:0]  rx_bits;
	logic [3:0]  tx_bits;
	logic [8:0]  rx_shift;
	logic [8:0]  rx_char;
	logic [15:0] divisor;
	logic        sck;
	logic        din;

	// Bus decode; a transfer completes on the edge where pready is seen high
	assign access  = psel_in & penable_in;
	assign wr_done = access & q.pready & pwrite_in;
	assign rd_done = access & q.pready & ~pwrite_in;
	assign mapped  = (paddr_in <= ADDR_RECEIVE_HOLDING_ONE) & (paddr_in[1:0] == 2'h0);

	// Mode selection; any receive enable turns the port into a receiver
	assign rx_mode = q.port_en & q.sync_mode & (q.single_rx | q.cont_rx);
	assign tx_mode = q.port_en & q.sync_mode & ~(q.single_rx | q.cont_rx) & q.tx_en;
	// Master clocks only while there is something to move; overrun halts it
	assign mst_run = q.master & ((rx_mode & ~q.ovr) | (tx_mode & q.tx_busy));
	assign divisor = {q.div_hi, q.div_lo};

	// Pins only reach logic after two flip-flops
	assign sck = q.sync2[1];
	assign din = q.sync2[0] ^ q.dat_pol;

	// Edge events: own baud phase as master, synchronised clock line as slave
	always_comb
	begin
		if (q.master)
		begin
			lead  = mst_run & (q.baud_cnt == 16'h0000) & ~q.phase;
			trail = mst_run & (q.baud_cnt == 16'h0000) & q.phase;
		end
		else
		begin
			lead  = q.port_en & q.sync_mode & (sck != q.clk_pol) & (q.ck_prev == q.clk_pol);
			trail = q.port_en & q.sync_mode & (sck == q.clk_pol) & (q.ck_prev != q.clk_pol);
		end
	end

	// Receive character assembly, LSB first
	assign rx_bits  = q.nine_rx ? BITS_LONG : BITS_SHORT;
	assign tx_bits  = q.nine_tx ? BITS_LONG : BITS_SHORT;
	assign rx_shift = {din, q.receive_shift_register[8:1]};
	assign rx_char  = q.nine_rx ? rx_shift : {1'b0, rx_shift[8:1]};
	assign rx_done  = rx_mode & ~q.ovr & trail & ((q.rx_cnt + 4'h1) == rx_bits);
	assign push     = rx_done & (q.count != 2'h2);
	assign pop      = rd_done & (paddr_in == ADDR_RECEIVE_HOLDING_ONE) & (q.count != 2'h0);

	// Next-state logic for the whole port
	always_comb
	begin
		d = q;
		d.sync1   = {clock_line_in, data_line_in};
		d.sync2   = q.sync1;
		d.ck_prev = sck;
		d.pready  = access & ~q.pready;
		d.pslverr = access & ~q.pready & ~mapped;

		// Read data is prepared in the first access cycle and held until release
		if (access & ~q.pready)
		begin
			d.prdata = 32'h0000_0000;
			unique case (paddr_in)
				ADDR_BAUD_CONTROL_ONE:
				begin
					d.prdata[BIT_CLOCK_POLARITY] = q.clk_pol;
					d.prdata[BIT_DATA_POLARITY]  = q.dat_pol;
				end
				ADDR_RECEIVE_STATUS_CONTROL_ONE:
				begin
					d.prdata[BIT_PORT_ENABLE] = q.port_en;
					d.prdata[BIT_NINE_RX]     = q.nine_rx;
					d.prdata[BIT_SINGLE_RX]   = q.single_rx;
					d.prdata[BIT_CONT_RX]     = q.cont_rx;
					d.prdata[BIT_RX_FLAG]     = q.rx_flag;
					d.prdata[BIT_OVERRUN]     = q.ovr;
					d.prdata[BIT_NINTH_RX]    = q.fifo[q.head][8] & (q.count != 2'h0);
				end
				ADDR_TRANSMIT_STATUS_CONTROL_ONE:
				begin
					d.prdata[BIT_MASTER_CLOCK] = q.master;
					d.prdata[BIT_NINE_TX]      = q.nine_tx;
					d.prdata[BIT_TX_ENABLE]    = q.tx_en;
					d.prdata[BIT_SYNC_MODE]    = q.sync_mode;
					d.prdata[BIT_TX_IDLE]      = ~q.tx_busy;
					d.prdata[BIT_NINTH_TX]     = q.ninth_tx;
				end
				ADDR_BAUD_DIVISOR_LOW_ONE:  d.prdata[7:0] = q.div_lo;
				ADDR_BAUD_DIVISOR_HIGH_ONE: d.prdata[7:0] = q.div_hi;
				ADDR_RECEIVE_HOLDING_ONE:   d.prdata[7:0] = q.fifo[q.head][7:0];
				default:                    d.prdata = 32'h0000_0000;
			endcase
		end

		// Software writes
		if (wr_done)
		begin
			unique case (paddr_in)
				ADDR_BAUD_CONTROL_ONE:
				begin
					d.clk_pol = pwdata_in[BIT_CLOCK_POLARITY];
					d.dat_pol = pwdata_in[BIT_DATA_POLARITY];
				end
				ADDR_RECEIVE_STATUS_CONTROL_ONE:
				begin
					d.port_en   = pwdata_in[BIT_PORT_ENABLE];
					d.nine_rx   = pwdata_in[BIT_NINE_RX];
					d.single_rx = pwdata_in[BIT_SINGLE_RX];
					d.cont_rx   = pwdata_in[BIT_CONT_RX];
				end
				ADDR_TRANSMIT_STATUS_CONTROL_ONE:
				begin
					d.master    = pwdata_in[BIT_MASTER_CLOCK];
					d.nine_tx   = pwdata_in[BIT_NINE_TX];
					d.tx_en     = pwdata_in[BIT_TX_ENABLE];
					d.sync_mode = pwdata_in[BIT_SYNC_MODE];
					d.ninth_tx  = pwdata_in[BIT_NINTH_TX];
				end
				ADDR_BAUD_DIVISOR_LOW_ONE:  d.div_lo = pwdata_in[7:0];
				ADDR_BAUD_DIVISOR_HIGH_ONE: d.div_hi = pwdata_in[7:0];
				ADDR_TRANSMIT_HOLDING_ONE:
				begin
					// Ninth bit is taken from the control bit as it stands now
					d.txh      = {q.ninth_tx, pwdata_in[7:0]};
					d.txh_full = 1'b1;
				end
				default:
				begin
					d.txh_full = q.txh_full;
				end
			endcase
		end

		// Master baud engine: each half period lasts divisor+1 clocks
		if (mst_run)
		begin
			if (q.baud_cnt == 16'h0000)
			begin
				d.baud_cnt = divisor;
				d.phase    = ~q.phase;
			end
			else
			begin
				d.baud_cnt = q.baud_cnt - 16'h0001;
			end
		end
		else
		begin
			// Not running: clock parks at idle level at once
			d.baud_cnt = divisor;
			d.phase    = 1'b0;
		end

		// Transmit: load shift register from holding register when free
		if (tx_mode & ~q.tx_busy & q.txh_full)
		begin
			d.transmit_shift_register      = q.txh;
			d.tx_busy  = 1'b1;
			d.tx_cnt   = 4'h0;
			d.txh_full = 1'b0;
		end
		else if (tx_mode & q.tx_busy & lead)
		begin
			// Data changes on the leading edge, valid at the trailing one
			d.pins.data_line = q.transmit_shift_register[0] ^ q.dat_pol;
			d.transmit_shift_register            = {1'b0, q.transmit_shift_register[8:1]};
			d.tx_cnt         = q.tx_cnt + 4'h1;
		end
		else if (tx_mode & q.tx_busy & trail & (q.tx_cnt == tx_bits))
		begin
			d.tx_busy = 1'b0;
		end

		// Receive shifting; leaving receive mode throws the partial character away
		if (~rx_mode)
		begin
			d.rx_cnt = 4'h0;
		end
		else if (~q.ovr & trail)
		begin
			d.receive_shift_register    = rx_shift;
			d.rx_cnt = rx_done ? 4'h0 : q.rx_cnt + 4'h1;
		end

		// Completed character: single receive always drops after one
		if (rx_done)
		begin
			d.single_rx = 1'b0;
		end

		// FIFO pop then push; a full FIFO is never overwritten
		if (pop)
		begin
			d.head  = ~q.head;
			d.count = q.count - 2'h1;
		end
		if (push)
		begin
			d.fifo[q.head ^ q.count[0]] = rx_char;
			d.count = d.count + 2'h1;
		end

		// Overrun clearing, then setting so a new overrun wins
		if (pop & q.ovr_single)
		begin
			d.ovr = 1'b0;
		end
		if (~d.cont_rx & ~q.ovr_single)
		begin
			d.ovr = 1'b0;
		end
		if (rx_done & (q.count == 2'h2))
		begin
			d.ovr        = 1'b1;
			d.ovr_single = q.single_rx & ~q.cont_rx;
		end

		// Disabling the port resets the serial machinery but not settings
		if (~d.port_en)
		begin
			d.count    = 2'h0;
			d.ovr      = 1'b0;
			d.tx_busy  = 1'b0;
			d.txh_full = 1'b0;
			d.rx_cnt   = 4'h0;
		end

		d.rx_flag = (d.count != 2'h0);

		// Pin drivers: clock only as master, data whenever in transmit mode, busy or not
		d.pins.clock_line    = d.clk_pol ^ d.phase;
		d.pins.clock_line_oe = d.port_en & d.sync_mode & d.master;
		d.pins.data_line_oe  = d.port_en & d.sync_mode & d.tx_en
			& ~(d.single_rx | d.cont_rx);
	end

	// State register
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			q        <= '0;
			q.div_lo <= RESET_DIVISOR;
			q.div_hi <= RESET_DIVISOR;
		end
		else
		begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign prdata_out                 = q.prdata;
	assign pready_out                 = q.pready;
	assign pslverr_out                = q.pslverr;
	assign clock_line_out             = q.pins.clock_line;
	assign clock_line_oe_out          = q.pins.clock_line_oe;
	assign data_line_out              = q.pins.data_line;
	assign data_line_oe_out           = q.pins.data_line_oe;
	assign receive_interrupt_flag_out = q.rx_flag;

	// Checks on the port's own behaviour
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// A software write in the completion cycle may legally re-arm reception
	sequence s_char_done;
		rx_done & q.single_rx & ~q.cont_rx & ~wr_done & ~q.tx_busy;
	endsequence

	sequence s_single_gone;
		(~q.single_rx & ~rx_mode) ##1 (clock_line_out == q.clk_pol);
	endsequence

	property p_single_stops;
		s_char_done |=> s_single_gone;
	endproperty
	a_single_stops: assert property (p_single_stops) else $error("single receive not cleared");

	property p_full_overrun;
		(rx_done & q.count == 2'h2 & ~pop & d.port_en) |=> (q.ovr & q.count == 2'h2);
	endproperty
	a_full_overrun: assert property (p_full_overrun) else $error("overrun missed");

	property p_flag_tracks;
		// Only a pop or a port reset may take the flag down
		(q.rx_flag & ~pop & d.port_en) |=> receive_interrupt_flag_out;
	endproperty
	a_flag_tracks: assert property (p_flag_tracks) else $error("receive flag wrong");

	property p_pop_count;
		(pop & ~push & d.port_en) |=> q.count == $past(q.count) - 2'h1;
	endproperty
	a_pop_count: assert property (p_pop_count) else $error("pop did not advance");

	property p_abort_idle;
		// Counter and clock settle one cycle after receive mode drops
		(q.master & q.cont_rx & ~q.single_rx & ~d.cont_rx & ~d.single_rx & ~q.tx_busy)
			|-> ##2 ((q.rx_cnt == 4'h0) & (clock_line_out == q.clk_pol));
	endproperty
	a_abort_idle: assert property (p_abort_idle) else $error("clock kept running");

	property p_tx_data;
		(tx_mode & q.tx_busy & lead) |=> data_line_out == ($past(q.transmit_shift_register[0]) ^ $past(q.dat_pol));
	endproperty
	a_tx_data: assert property (p_tx_data) else $error("transmit bit wrong");

	property p_clock_idle;
		(~mst_run & $stable(q.clk_pol)) [*2] |=> clock_line_out == q.clk_pol;
	endproperty
	a_clock_idle: assert property (p_clock_idle) else $error("clock not idle");

	property p_overrun_read;
		(q.ovr & q.ovr_single & pop & ~rx_done) |=> ~q.ovr;
	endproperty
	a_overrun_read: assert property (p_overrun_read) else $error("overrun kept");

	property p_hold_on_overrun;
		(q.ovr & ~pop) |=> $stable(q.fifo);
	endproperty
	a_hold_on_overrun: assert property (p_hold_on_overrun) else $error("fifo changed");

	property p_nine_len;
		(rx_done & q.nine_rx) |-> q.rx_cnt == 4'h8;
	endproperty
	a_nine_len: assert property (p_nine_len) else $error("nine-bit length wrong");

endmodule
`default_nettype wire

// file: tb/ssm_peer.sv
// Peer on the serial lines: shifts a word out, captures the line, can clock as master
`timescale 1ns/100ps
`default_nettype none
module ssm_peer
(
	input  wire logic       line_clock_in,
	input  wire logic       line_data_in,
	input  wire logic       idle_level_in,
	input  wire logic [3:0] bits_in,
	input  wire logic [8:0] word_in,
	input  wire logic       load_in,
	input  wire logic       go_in,
	output var  logic       clock_out,
	output var  logic       data_out,
	output var  logic [8:0] got_out
);
	int   idx = 0;
	int   ridx = 0;
	logic run = 1'b0;

	// Known line levels from the start
	initial
	begin
		clock_out = 1'b0;
		data_out = 1'b0;
	end

	// Fresh word: restart both bit pointers
	always @(posedge load_in)
	begin
		idx = 0;
		ridx = 0;
		got_out = 9'h000;
	end

	// Clock rests at the idle level between frames, never free running
	always @(idle_level_in)
		if (!run)
			clock_out = idle_level_in;

	// Leading edge changes our data, trailing edge samples the line
	always @(line_clock_in)
	begin
		if (line_clock_in !== idle_level_in)
		begin
			data_out = word_in[idx % int'(bits_in)];
			idx++;
		end
		else if (ridx < int'(bits_in))
		begin
			got_out[ridx] = line_data_in;
			ridx++;
		end
	end

	// Master role: one 64 ns clock per bit of the character, no extra cycles
	always @(posedge go_in)
	begin
		run = 1'b1;
		#7;
		repeat (bits_in)
		begin
			#32 clock_out = ~idle_level_in;
			#32 clock_out = idle_level_in;
		end
		run = 1'b0;
	end
endmodule
`default_nettype wire

// file: tb/sync_serial_master_rx_tx_test.sv
// Bench for the synchronous serial port: APB tasks, peer on the lines, receive and send
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sync_serial_master_rx_tx_test
	import ssm_pkg::*;
;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        psel_in = 1'b0;
	logic        penable_in = 1'b0;
	logic        pwrite_in = 1'b0;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0;
	logic [31:0] prdata_out;
	logic        pready_out;
	logic        pslverr_out;
	logic        c_out;
	logic        c_oe;
	logic        d_out;
	logic        d_oe;
	logic        flag;
	logic        p_cout;
	logic        p_dout;
	logic [8:0]  got;
	logic        pol = 1'b0;
	logic [3:0]  bits = 4'h8;
	logic [8:0]  word = 9'h000;
	logic        load_p = 1'b0;
	logic        go = 1'b0;
	logic [31:0] rdat;
	logic        rerr;
	int          n_mismatch = 0;
	int          checked = 0;
	int          n_edge = 0;
	int          e1;
	logic [7:0]  regs [5] = '{ADDR_BAUD_CONTROL_ONE, ADDR_RECEIVE_STATUS_CONTROL_ONE,
		ADDR_BAUD_DIVISOR_LOW_ONE, ADDR_BAUD_DIVISOR_HIGH_ONE, ADDR_TRANSMIT_HOLDING_ONE};
	// Line levels: the port wins while its driver is on
	wire logic   cl = c_oe ? c_out : p_cout;
	wire logic   dl = d_oe ? d_out : p_dout;

	ssm_port u_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .clock_line_in(cl), .clock_line_out(c_out),
		.clock_line_oe_out(c_oe), .data_line_in(dl), .data_line_out(d_out),
		.data_line_oe_out(d_oe), .receive_interrupt_flag_out(flag));
	ssm_peer u_peer (.line_clock_in(cl), .line_data_in(dl), .idle_level_in(pol),
		.bits_in(bits), .word_in(word), .load_in(load_p), .go_in(go),
		.clock_out(p_cout), .data_out(p_dout), .got_out(got));

	// 200 MHz clock
	initial
	begin
		forever
			#2.5 clk_in = ~clk_in;
	end

	// Rising edges of the port's own clock drive, idle low assumed
	always @(posedge c_out)
		n_edge++;

	task automatic give_verdict();
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic timeout();
		n_mismatch++;
		give_verdict();
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		int n;
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= wd;
		@(posedge clk_in);
		penable_in <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 40);
		if (n >= 40)
			timeout();
		rdat = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	// Reads a register until bit b shows v, bounded
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		int n;
		for (n = 0; n < 400; n++)
		begin
			rd(a);
			if (rdat[b] === v)
				break;
		end
		if (n >= 400)
			timeout();
	endtask

	// Negative k waits for the receive flag, else until the edge count n_edge reaches k
	task automatic wait_for(input int k);
		int n;
		for (n = 0; n < 5000; n++)
		begin
			if (k < 0 ? flag === 1'b1 : n_edge >= k)
				break;
			@(posedge clk_in);
		end
		if (n >= 5000)
			timeout();
	endtask

	// New character for the peer, pointers restarted
	task automatic load(input logic [8:0] w, input logic [3:0] b);
		word <= w;
		bits <= b;
		load_p <= 1'b1;
		@(posedge clk_in);
		load_p <= 1'b0;
		@(posedge clk_in);
	endtask

	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		foreach (regs[i])
		begin
			rd(regs[i]);
			`CHK(rdat, 32'h0)
		end
		rd(8'h1c);
		`CHK({rerr, rdat}, {1'b1, 32'h0})
		wr(ADDR_BAUD_DIVISOR_LOW_ONE, 32'h07);
		rd(ADDR_BAUD_DIVISOR_LOW_ONE);
		`CHK(rdat, 32'h07)
		wr(ADDR_TRANSMIT_STATUS_CONTROL_ONE, 32'h90);
		wr(ADDR_RECEIVE_STATUS_CONTROL_ONE, 32'h80);
		`CHK({c_oe, c_out}, 2'b10)
		// Continuous receive dropped mid-character
		load(9'h00f, 4'h8);
		e1 = n_edge;
		wr(ADDR_RECEIVE_STATUS_CONTROL_ONE, 32'h90);
		wait_for(e1 + 4);
		wr(ADDR_RECEIVE_STATUS_CONTROL_ONE, 32'h80);
		repeat (300) @(posedge clk_in);
		e1 = n_edge;
		repeat (100) @(posedge clk_in);
		`CHK(n_edge, e1)
		`CHK(flag, 1'b0)
		// Single receive of one whole character
		load(9'h096, 4'h8);
		n_edge = 0;
		wr(ADDR_RECEIVE_STATUS_CONTROL_ONE, 32'ha0);
		wait_for(-1);
		`CHK(d_oe, 1'b0)
		repeat (100) @(posedge clk_in);
		`CHK(n_edge, 8)
		rd(ADDR_RECEIVE_STATUS_CONTROL_ONE);
		`CHK(rdat[7:1], 7'h44)
		rd(ADDR_RECEIVE_HOLDING_ONE);
		`CHK(rdat, 32'h96)
		`CHK(flag, 1'b0)
		// Both enables, nine bits, run into overrun
		load(9'h1c3, 4'h9);
		wr(ADDR_RECEIVE_STATUS_CONTROL_ONE, 32'hf0);
		poll(ADDR_RECEIVE_STATUS_CONTROL_ONE, 1, 1'b1);
		`CHK(rdat[7:0], 8'hdb)
		rd(ADDR_RECEIVE_HOLDING_ONE);
		`CHK(rdat, 32'hc3)
		rd(ADDR_RECEIVE_STATUS_CONTROL_ONE);
		`CHK({flag, rdat[0]}, 2'b11)
		rd(ADDR_RECEIVE_HOLDING_ONE);
		`CHK(rdat, 32'hc3)
		rd(ADDR_RECEIVE_STATUS_CONTROL_ONE);
		`CHK(rdat[7:1], 7'h69)
		wr(ADDR_RECEIVE_STATUS_CONTROL_ONE, 32'hc0);
		rd(ADDR_RECEIVE_STATUS_CONTROL_ONE);
		`CHK(rdat[7:1], 7'h60)
		// Three single receives with no read: overrun, cleared by one read
		load(9'h0a5, 4'h8);
		repeat (3)
		begin
			wr(ADDR_RECEIVE_STATUS_CONTROL_ONE, 32'ha0);
			poll(ADDR_RECEIVE_STATUS_CONTROL_ONE, 5, 1'b0);
		end
		rd(ADDR_RECEIVE_STATUS_CONTROL_ONE);
		`CHK(rdat[7:1], 7'h45)
		rd(ADDR_RECEIVE_HOLDING_ONE);
		`CHK(rdat, 32'ha5)
		rd(ADDR_RECEIVE_STATUS_CONTROL_ONE);
		`CHK(rdat[7:1], 7'h44)
		rd(ADDR_RECEIVE_HOLDING_ONE);
		`CHK(rdat, 32'ha5)
		// Master send with inverted data
		wr(ADDR_BAUD_CONTROL_ONE, 32'h20);
		wr(ADDR_TRANSMIT_STATUS_CONTROL_ONE, 32'hb0);
		load(9'h000, 4'h8);
		n_edge = 0;
		wr(ADDR_TRANSMIT_HOLDING_ONE, 32'h3c);
		wait_for(8);
		`CHK(d_oe, 1'b1)
		repeat (100) @(posedge clk_in);
		`CHK(n_edge, 8)
		`CHK(got[7:0], 8'hc3)
		// Nine-bit send: ninth bit loaded before the low byte
		wr(ADDR_TRANSMIT_STATUS_CONTROL_ONE, 32'hf1);
		load(9'h000, 4'h9);
		n_edge = 0;
		wr(ADDR_TRANSMIT_HOLDING_ONE, 32'h3c);
		wait_for(9);
		repeat (100) @(posedge clk_in);
		`CHK(n_edge, 9)
		`CHK(got, 9'h0c3)
		rd(ADDR_TRANSMIT_STATUS_CONTROL_ONE);
		`CHK(rdat[7:0], 8'hf3)
		// Idle high clock, then slave receive from the peer's clock
		wr(ADDR_BAUD_CONTROL_ONE, 32'h10);
		`CHK(c_out, 1'b1)
		pol <= 1'b1;
		wr(ADDR_TRANSMIT_STATUS_CONTROL_ONE, 32'h10);
		`CHK(c_oe, 1'b0)
		load(9'h05a, 4'h8);
		wr(ADDR_RECEIVE_STATUS_CONTROL_ONE, 32'h90);
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		wait_for(-1);
		rd(ADDR_RECEIVE_HOLDING_ONE);
		`CHK(rdat, 32'h5a)
		// Slave send: data changes on the peer's leading edges
		wr(ADDR_RECEIVE_STATUS_CONTROL_ONE, 32'h80);
		wr(ADDR_TRANSMIT_STATUS_CONTROL_ONE, 32'h30);
		load(9'h000, 4'h8);
		wr(ADDR_TRANSMIT_HOLDING_ONE, 32'h81);
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		repeat (200) @(posedge clk_in);
		`CHK({d_oe, got[7:0]}, {1'b1, 8'h81})
		give_verdict();
	end
endmodule
`default_nettype wire
